// >>> core/ssm_modulator.sv
// spread-spectrum modulator for two fractional dividers with shared tick and phase share
`timescale 1ns/1ns
`include "ssm_params.svh"
`default_nettype none

module ssm_modulator
    import ssm_pkg::*;
(
    input  wire logic                     mclk_i,        // 60MHz system clock
    input  wire logic                     arst_n_i,      // async reset, low active
    input  wire logic                     cfg_a_wr_i,    // write strobe, divider a config
    input  wire logic                     cfg_b_wr_i,    // write strobe, divider b config
    input  wire logic [31:0]              cfg_wdata_i,   // config write data
    input  wire logic                     share_i,       // phase share option
    input  wire logic [`SSM_FRAC_W-1:0]   frac_a_i,      // nominal ratio, frac_divider_a
    input  wire logic [`SSM_FRAC_W-1:0]   frac_b_i,      // nominal ratio, frac_divider_b
    output logic      [31:0]              cfg_a_o,       // config readback, divider a
    output logic      [31:0]              cfg_b_o,       // config readback, divider b
    output logic      [`SSM_FRAC_W-1:0]   ratio_a_o,     // modulated ratio, frac_divider_a
    output logic      [`SSM_FRAC_W-1:0]   ratio_b_o,     // modulated ratio, frac_divider_b
    output logic                          tick_o         // modulation tick pulse
);

    ////////////////////////////////////////////////////////////////////////////
    ssm_cfg_t                  cfg_a_reg, cfg_a_next;
    ssm_cfg_t                  cfg_b_reg, cfg_b_next;
    logic [`SSM_TICK_CNT_W-1:0] div_reg, div_next;
    logic                      tick_reg, tick_next;

    always_comb begin
        cfg_a_next = cfg_a_reg;
        cfg_b_next = cfg_b_reg;
        if (cfg_a_wr_i) begin
            cfg_a_next = ssm_cfg_t'(cfg_wdata_i & `SSM_RESV_MASK);
        end
        if (cfg_b_wr_i) begin
            cfg_b_next = ssm_cfg_t'(cfg_wdata_i & `SSM_RESV_MASK);
        end
        // free-running divider shared by both ramps so equal rates stay in step
        div_next  = div_reg + `SSM_TICK_CNT_W'(1);
        tick_next = (div_reg == `SSM_TICK_CNT_W'(`SSM_TICK_DIV - 1));
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_a_reg <= ssm_cfg_t'(`SSM_RST_CFG);
            cfg_b_reg <= ssm_cfg_t'(`SSM_RST_CFG);
            div_reg   <= '0;
            tick_reg  <= 1'b0;
        end else begin
            cfg_a_reg <= cfg_a_next;
            cfg_b_reg <= cfg_b_next;
            div_reg   <= div_next;
            tick_reg  <= tick_next;
        end
    end

    assign cfg_a_o = cfg_a_reg;
    assign cfg_b_o = cfg_b_reg;
    assign tick_o  = tick_reg;

    ////////////////////////////////////////////////////////////////////////////
    // phase share: b follows a's enable edge so both ramps restart together
    logic en_a_d_reg, en_a_d_next;
    logic a_start, b_restart, run_b;

    always_comb begin
        en_a_d_next = cfg_a_reg.en;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_a_d_reg <= 1'b0;
        end else begin
            en_a_d_reg <= en_a_d_next;
        end
    end

    assign a_start   = cfg_a_reg.en & ~en_a_d_reg;
    assign b_restart = share_i & a_start;
    // with share, b waits for a: b enabled alone stays unmodulated
    assign run_b     = cfg_b_reg.en & (~share_i | cfg_a_reg.en);

    ////////////////////////////////////////////////////////////////////////////
    ssm_ramp u_ramp_a (
        .mclk_i    (mclk_i),
        .arst_n_i  (arst_n_i),
        .tick_i    (tick_reg),
        .run_i     (cfg_a_reg.en),
        .restart_i (a_start),
        .center_i  (cfg_a_reg.center),
        .ampl_i    (cfg_a_reg.ampl),
        .step_i    (cfg_a_reg.step),
        .frac_i    (frac_a_i),
        .ratio_o   (ratio_a_o)
    );

    ssm_ramp u_ramp_b (
        .mclk_i    (mclk_i),
        .arst_n_i  (arst_n_i),
        .tick_i    (tick_reg),
        .run_i     (run_b),
        .restart_i (b_restart),
        .center_i  (cfg_b_reg.center),
        .ampl_i    (cfg_b_reg.ampl),
        .step_i    (cfg_b_reg.step),
        .frac_i    (frac_b_i),
        .ratio_o   (ratio_b_o)
    );

endmodule // ssm_modulator

////////////////////////////////////////////////////////////////////////////////
// one triangular ramp; offset kept in 2^-30 units of nominal (ampl << 16 = ampl * 2^-14)
module ssm_ramp
    import ssm_pkg::*;
(
    input  wire logic                     mclk_i,     // system clock
    input  wire logic                     arst_n_i,   // async reset, low active
    input  wire logic                     tick_i,     // modulation tick
    input  wire logic                     run_i,      // modulation enabled
    input  wire logic                     restart_i,  // restart ramp at zero offset, heading down
    input  wire logic                     center_i,   // centred shape
    input  wire logic [7:0]               ampl_i,     // amplitude
    input  wire logic [15:0]              step_i,     // ramp step
    input  wire logic [`SSM_FRAC_W-1:0]   frac_i,     // nominal ratio
    output logic      [`SSM_FRAC_W-1:0]   ratio_o     // modulated ratio
);
    ssm_state_t                       st_reg, st_next;
    logic signed [`SSM_ACC_W-1:0]     acc_reg, acc_next;
    logic        [`SSM_FRAC_W-1:0]    ratio_reg, ratio_next;
    logic signed [`SSM_ACC_W-1:0]     lim_lo, lim_hi, sum, dif;
    // clamping at the limit keeps the peaks exact even when the step
    // does not divide the span; the cost is a slightly short last step
    // restart is not aligned to the tick: the first step waits up to 4 clocks

    always_comb begin
        lim_lo = -$signed({8'h00, ampl_i, 16'h0000});
        lim_hi = center_i ? $signed({8'h00, ampl_i, 16'h0000})
                          : '0;
        sum = acc_reg + $signed({16'h0000, step_i});
        dif = acc_reg - $signed({16'h0000, step_i});
        st_next  = st_reg;
        acc_next = acc_reg;
        unique case (st_reg)
            SSM_IDLE: begin
                acc_next = '0;
                if (run_i) begin
                    st_next = SSM_DOWN;
                end
            end
            SSM_DOWN: begin
                if (tick_i) begin
                    if (dif <= lim_lo) begin
                        acc_next = lim_lo;
                        st_next  = SSM_UP;
                    end else begin
                        acc_next = dif;
                    end
                end
            end
            SSM_UP: begin
                if (tick_i) begin
                    if (sum >= lim_hi) begin
                        acc_next = lim_hi;
                        st_next  = SSM_DOWN;
                    end else begin
                        acc_next = sum;
                    end
                end
            end
            default: begin
                st_next  = SSM_IDLE;
                acc_next = '0;
            end
        endcase
        if (!run_i) begin
            st_next  = SSM_IDLE;
            acc_next = '0;
        end else if (restart_i) begin
            st_next  = SSM_DOWN;
            acc_next = '0;
        end
        // offset scaled so ratio lsb tracks 2^-30; ratio = nominal - offset
        ratio_next = run_i ? frac_i - `SSM_FRAC_W'($signed(acc_reg) >>> 0)
                           : frac_i;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg    <= SSM_IDLE;
            acc_reg   <= '0;
            ratio_reg <= '0;
        end else begin
            st_reg    <= st_next;
            acc_reg   <= acc_next;
            ratio_reg <= ratio_next;
        end
    end

    assign ratio_o = ratio_reg;

endmodule // ssm_ramp

`default_nettype wire

// >>> core/ssm_params.svh
// constants for the spread-spectrum modulator: field positions, reset values, tick divider
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH

`define SSM_EN_BIT         31
`define SSM_SHAPE_BIT      30
`define SSM_AMPL_MSB       23
`define SSM_AMPL_LSB       16
`define SSM_STEP_MSB       15
`define SSM_STEP_LSB       0
`define SSM_RESV_MASK      32'hC0FF_FFFF
`define SSM_RST_CFG        32'h0051_2B8C
`define SSM_SYS_CLK_MHZ    60
`define SSM_TICK_DIV       4
`define SSM_TICK_CNT_W     2
`define SSM_FRAC_W         34
`define SSM_ACC_W          32

`endif

// >>> core/ssm_pkg.sv
// types shared by the spread-spectrum modulator
`default_nettype none
package ssm_pkg;
    typedef struct packed {
        logic        en;
        logic        center;
        logic [5:0]  resv;
        logic [7:0]  ampl;
        logic [15:0] step;
    } ssm_cfg_t;

    typedef enum logic [1:0] {
        SSM_IDLE = 2'b00,
        // gray along idle -> down <-> up, one bit per step
        SSM_DOWN = 2'b01,
        SSM_UP   = 2'b11
    } ssm_state_t;
endpackage
`default_nettype wire

// >>> testbench/ssm_modulator_chk.sv
// port assertions for the spread-spectrum modulator
`timescale 1ns/1ns
`include "ssm_params.svh"
`default_nettype none
module ssm_modulator_chk (
    input wire logic                   mclk_i,      // clock
    input wire logic                   arst_n_i,    // reset
    input wire logic                   cfg_a_wr_i,  // write a
    input wire logic                   cfg_b_wr_i,  // write b
    input wire logic [31:0]            cfg_wdata_i, // write data
    input wire logic                   share_i,     // phase share
    input wire logic [`SSM_FRAC_W-1:0] frac_a_i,    // nominal a
    input wire logic [`SSM_FRAC_W-1:0] frac_b_i,    // nominal b
    input wire logic [31:0]            cfg_a_o,     // config a
    input wire logic [31:0]            cfg_b_o,     // config b
    input wire logic [`SSM_FRAC_W-1:0] ratio_a_o,   // ratio a
    input wire logic [`SSM_FRAC_W-1:0] ratio_b_o,   // ratio b
    input wire logic                   tick_o       // tick
);
    logic [`SSM_FRAC_W-1:0] amp_a;
    assign amp_a = {10'h0, cfg_a_o[23:16], 16'h0};
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////////////
    chk_tick_gap: assert property (tick_o |=> !tick_o [*3] ##1 tick_o)
        else $error("tick spacing wrong");
    chk_cfg_a_wr: assert property (cfg_a_wr_i |=> cfg_a_o == ($past(cfg_wdata_i) & `SSM_RESV_MASK))
        else $error("config a readback wrong");
    chk_cfg_b_wr: assert property (cfg_b_wr_i |=> cfg_b_o == ($past(cfg_wdata_i) & `SSM_RESV_MASK))
        else $error("config b readback wrong");
    chk_cfg_hold: assert property (!cfg_a_wr_i && !cfg_b_wr_i |=> $stable(cfg_a_o) && $stable(cfg_b_o))
        else $error("config changed without write");
    chk_off_ratio: assert property ((!cfg_a_o[31] && $stable(frac_a_i)) [*4] |-> ratio_a_o == frac_a_i)
        else $error("ratio modulated while disabled");
    chk_down_span: assert property ((cfg_a_o[31] && !cfg_a_o[30] && $stable(frac_a_i)) [*3]
        |-> ratio_a_o >= frac_a_i && ratio_a_o <= frac_a_i + amp_a) else $error("down spread out of range");
    chk_ctr_span: assert property ((cfg_a_o[31] && cfg_a_o[30] && $stable(frac_a_i)) [*3]
        |-> ratio_a_o + amp_a >= frac_a_i && ratio_a_o <= frac_a_i + amp_a) else $error("center spread out of range");
    chk_share_idle: assert property ((share_i && !cfg_a_o[31] && $stable(frac_b_i)) [*4]
        |-> ratio_b_o == frac_b_i) else $error("b modulated before a enabled");
    chk_ramp_moves: assert property ($rose(cfg_a_o[31]) && cfg_a_o[15:0] != 16'h0 && cfg_a_o[23:16] != 8'h0
        |-> ##[2:12] ratio_a_o != frac_a_i) else $error("ramp did not start");
endmodule // ssm_modulator_chk
bind ssm_modulator ssm_modulator_chk u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cfg_a_wr_i(cfg_a_wr_i),
    .cfg_b_wr_i(cfg_b_wr_i), .cfg_wdata_i(cfg_wdata_i), .share_i(share_i), .frac_a_i(frac_a_i),
    .frac_b_i(frac_b_i), .cfg_a_o(cfg_a_o), .cfg_b_o(cfg_b_o), .ratio_a_o(ratio_a_o),
    .ratio_b_o(ratio_b_o), .tick_o(tick_o));
`default_nettype wire

// >>> testbench/ssm_modulator_tb.sv
// self-checking bench for the spread-spectrum modulator
`timescale 1ns/1ns
`include "ssm_params.svh"
`default_nettype none
module ssm_modulator_tb;
    logic mclk_i = 0, arst_n_i = 0, cfg_a_wr_i = 0, cfg_b_wr_i = 0, share_i = 0, tick_o, c;
    logic [31:0] cfg_wdata_i = 0, cfg_a_o, cfg_b_o, w, seed = 32'hD268;
    logic [33:0] frac_a_i = 0, frac_b_i = 0, ratio_a_o, ratio_b_o;
    logic signed [34:0] oa, ob, lo, hi, lob, hib, amp;
    logic [7:0] ampl;
    int miscompares = 0, checked = 0, fk;
    always #5 mclk_i = ~mclk_i;
    ssm_modulator DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cfg_a_wr_i(cfg_a_wr_i), .cfg_b_wr_i(cfg_b_wr_i),
        .cfg_wdata_i(cfg_wdata_i), .share_i(share_i), .frac_a_i(frac_a_i), .frac_b_i(frac_b_i),
        .cfg_a_o(cfg_a_o), .cfg_b_o(cfg_b_o), .ratio_a_o(ratio_a_o), .ratio_b_o(ratio_b_o), .tick_o(tick_o));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // centred shape doubles the step since the ramp travels twice as far
    function automatic logic [15:0] step_of(input logic [7:0] a, input int f, input logic ctr);
        longint s;
        s = (ctr ? 2 : 1) * longint'(a) * 65536 * f / 15000;
        return s[15:0];
    endfunction
    task chk(input logic ok, input string m);
        checked++;
        if (!ok) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task results;
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task wr(input logic to_a, input logic [31:0] d);
        @(negedge mclk_i);
        cfg_a_wr_i = to_a;
        cfg_b_wr_i = !to_a;
        cfg_wdata_i = d;
        @(negedge mclk_i);
        cfg_a_wr_i = 0;
        cfg_b_wr_i = 0;
        chk((to_a ? cfg_a_o : cfg_b_o) === (d & `SSM_RESV_MASK), "config readback");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge mclk_i);
        arst_n_i = 1;
        chk(cfg_a_o === `SSM_RST_CFG && cfg_b_o === `SSM_RST_CFG, "reset config");
        for (int i = 0; i < 8; i++) begin
            ampl = 8'(1 + xs() % 81);
            fk = 30 + int'(xs() % 34);
            c = i[0];
            if (i == 6) begin
                ampl = 8'hFF;
                fk = 30;
            end
            wr(1'b1, 32'h0);
            wr(1'b0, 32'h0);
            share_i = i[1];
            frac_a_i = {2'b01, xs()};
            frac_b_i = {2'b01, xs()};
            // b first, as phase sharing requires; reserved bits set on purpose
            w = {1'b1, c, 6'h2A, ampl, step_of(ampl, fk, c)};
            wr(1'b0, w);
            repeat (10) @(negedge mclk_i);
            wr(1'b1, w);
            lo = 0;
            hi = 0;
            lob = 0;
            hib = 0;
            amp = {11'h0, ampl, 16'h0};
            repeat (4400) begin
                @(negedge mclk_i);
                oa = $signed({1'b0, ratio_a_o}) - $signed({1'b0, frac_a_i});
                ob = $signed({1'b0, ratio_b_o}) - $signed({1'b0, frac_b_i});
                lo = (oa < lo) ? oa : lo;
                hi = (oa > hi) ? oa : hi;
                lob = (ob < lob) ? ob : lob;
                hib = (ob > hib) ? ob : hib;
                if (share_i) chk(oa === ob, "shared phase differs");
            end
            chk(hi === amp && lo === (c ? -amp : 35'sh0), "ramp extremes");
            chk(hib === amp && lob === (c ? -amp : 35'sh0), "ramp extremes b");
        end
        // mid-run reset must bring back the power-up configuration
        @(negedge mclk_i);
        arst_n_i = 0;
        #1;
        chk(cfg_a_o === `SSM_RST_CFG && cfg_b_o === `SSM_RST_CFG, "mid-run reset config");
        chk(ratio_a_o === 34'h0 && ratio_b_o === 34'h0, "mid-run reset ratio");
        repeat (2) @(negedge mclk_i);
        arst_n_i = 1;
        repeat (30) @(negedge mclk_i);
        chk(ratio_a_o === frac_a_i && ratio_b_o === frac_b_i, "modulated after reset");
        results();
    end
endmodule // ssm_modulator_tb
`default_nettype wire
